// File: inc/fpasm_pkg.sv
package fpasm_pkg;
    localparam int WIDTH = 16;
    localparam int PROD_WIDTH = 2 * WIDTH;
    localparam int GROUPS = WIDTH / 2;

    typedef enum logic [2:0] {
        OP_ADD,
        OP_SUB,
        OP_MUL_SHIFT,
        OP_MUL_BOOTH
    } fpasm_op_t;

    typedef enum logic [1:0] {
        ROUND_TRUNC,
        ROUND_NEAREST
    } fpasm_round_t;

    localparam logic [WIDTH-1:0] FRAC_MINUS_ONE = 16'h8000;
    localparam logic [WIDTH-1:0] FRAC_MAX_POS = 16'h7fff;
    localparam logic [PROD_WIDTH-1:0] ROUND_HALF = 32'h0000_8000;
endpackage : fpasm_pkg

// File: src/fpasm_booth_cell.sv
`timescale 1ns/1ns
`default_nettype none
// One radix-4 recoding cell: a three-bit window picks 0, +-1x or +-2x
module fpasm_booth_cell
(
    input wire logic [2:0] window,
    input wire logic [fpasm_pkg::PROD_WIDTH-1:0] mcand,
    output logic [fpasm_pkg::PROD_WIDTH-1:0] part
);
    always_comb
    begin
        unique case (window) // RULE_17
            3'h1, 3'h2: part = mcand;
            3'h3: part = mcand << 1;
            3'h4: part = -(mcand << 1);
            3'h5, 3'h6: part = -mcand;
            3'h0, 3'h7: part = '0;
        endcase
    end
endmodule : fpasm_booth_cell
`default_nettype wire

// File: src/fpasm_datapath.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// (RULE_01) Widen signed operands by copying sign; unsigned operands by zeros.
// (RULE_02) Narrow signed value one bit only if top magnitude bit equals sign.
// (RULE_03) Non-overflowing sum takes sign bit from plain full-adder sum output.
// (RULE_04) Where overflow possible, extend both operands and add one cell for N+1 bits.
// (RULE_05) Subtract by XOR-inverting subtrahend and forcing carry-in to one.
// (RULE_06) Unsigned subtract prepends zero sign bits; sign dropped when non-negative.
// (RULE_07) Unsigned add overflows exactly when carry leaves the top bit.
// (RULE_08) Unsigned subtract is negative when no carry leaves the top bit.
// (RULE_09) Signed overflow is carry into sign XOR carry out of sign.
// (RULE_10) Shift-and-add: add multiplicand shifted by position for each one bit.
// (RULE_11) Signed multiply sign-extends partials and subtracts the sign-bit partial.
// (RULE_12) Unsigned fractions use the same multiply sequence as unsigned integers.
// (RULE_13) Signed fraction product is shifted left one place to align weights.
// (RULE_14) Operand-format product truncates low half or rounds with it.
// (RULE_15) Signed fraction -1.0 times -1.0 is flagged as overflow.
// (RULE_16) Booth scan adds at 1-to-0, subtracts at 0-to-1, skips equal bits.
// (RULE_17) Radix-4 groups decode to nop, +-1x or +-2x.
// (RULE_18) Result and flags are registered one clock after operands are taken.
module fpasm_datapath
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire fpasm_pkg::fpasm_op_t op,
    input wire logic is_signed,
    input wire logic is_frac,
    input wire fpasm_pkg::fpasm_round_t round_mode,
    input wire logic [fpasm_pkg::WIDTH-1:0] opa,
    input wire logic [fpasm_pkg::WIDTH-1:0] opb,
    output logic out_valid,
    output logic [fpasm_pkg::WIDTH:0] sum_wide,
    output logic [fpasm_pkg::WIDTH-1:0] result,
    output logic [fpasm_pkg::PROD_WIDTH-1:0] product,
    output logic carry_out,
    output logic overflow,
    output logic negative,
    output logic narrowable
);
    localparam int W = fpasm_pkg::WIDTH;
    localparam int PW = fpasm_pkg::PROD_WIDTH;

    typedef struct packed {
        logic out_valid;
        logic [W:0] sum_wide;
        logic [W-1:0] result;
        logic [PW-1:0] product;
        logic carry_out;
        logic overflow;
        logic negative;
        logic narrowable;
    } fpasm_state_t;

    fpasm_state_t st;
    fpasm_state_t next_st;

    // Widening by sign copy or zero fill
    function automatic logic [PW-1:0] widen(input logic [W-1:0] v, input logic sgn);
        widen = {{(PW-W){sgn & v[W-1]}}, v}; // RULE_01
    endfunction : widen

    logic [PW-1:0] mcand_wide;
    logic [W:0] booth_bits;
    logic [PW-1:0] booth_part [fpasm_pkg::GROUPS];

    // Radix-4 windows need one bit below bit zero; the top window ends at the multiplier's top bit
    assign mcand_wide = widen(opa, is_signed);
    assign booth_bits = {opb, 1'b0};

    genvar g;
    generate
        for (g = 0; g < fpasm_pkg::GROUPS; g++)
        begin : g_booth
            fpasm_booth_cell u_cell
            (
                .window(booth_bits[2*g+2:2*g]),
                .mcand(mcand_wide << (2 * g)),
                .part(booth_part[g])
            );
        end
    endgenerate

    always_comb
    begin
        logic [W-1:0] b_in;
        logic cin;
        logic [W-1:0] low_sum;
        logic c_into_sign;
        logic c_out_sign;
        logic [W:0] ext_sum;
        logic [PW-1:0] prod;
        logic [PW-1:0] aligned;
        logic [PW-1:0] rounded;
        logic [PW-1:0] top_group;
        logic mul_ovf;
        logic [W-1:0] tmp;

        b_in = '0;
        cin = 1'b0;
        low_sum = '0;
        c_into_sign = 1'b0;
        c_out_sign = 1'b0;
        ext_sum = '0;
        prod = '0;
        aligned = '0;
        rounded = '0;
        top_group = '0;
        mul_ovf = 1'b0;
        tmp = '0;

        next_st = st;
        next_st.out_valid = in_valid; // RULE_18

        if (in_valid)
        begin
            unique case (op)
                fpasm_pkg::OP_ADD, fpasm_pkg::OP_SUB:
                begin
                    // Controlled inversion turns the adder into a subtractor
                    cin = (op == fpasm_pkg::OP_SUB); // RULE_05
                    b_in = opb ^ {W{cin}}; // RULE_05
                    {c_into_sign, low_sum[W-2:0]} = {1'b0, opa[W-2:0]} + {1'b0, b_in[W-2:0]}
                        + {{(W-1){1'b0}}, cin};
                    // Sign cell is a plain full adder; its sum is the sign bit
                    {c_out_sign, low_sum[W-1]} = {1'b0, opa[W-1]} + {1'b0, b_in[W-1]}
                        + {1'b0, c_into_sign}; // RULE_03
                    // Extra cell over extended operands gives the N+1-bit result
                    if (is_signed)
                    begin
                        ext_sum = {opa[W-1] ^ b_in[W-1] ^ c_out_sign, low_sum}; // RULE_04
                        next_st.overflow = c_into_sign ^ c_out_sign; // RULE_09
                        next_st.negative = ext_sum[W]; // RULE_04
                    end
                    else if (cin)
                    begin
                        // Zero sign bits prepended; inverted one plus carry
                        ext_sum = {~c_out_sign, low_sum}; // RULE_06
                        next_st.negative = ~c_out_sign; // RULE_08
                        next_st.overflow = ~c_out_sign; // RULE_08
                    end
                    else
                    begin
                        ext_sum = {c_out_sign, low_sum}; // RULE_04
                        next_st.overflow = c_out_sign; // RULE_07
                        next_st.negative = 1'b0;
                    end
                    next_st.carry_out = c_out_sign; // RULE_07
                    next_st.sum_wide = ext_sum;
                    // Unsigned non-negative difference drops its sign bit
                    next_st.result = low_sum; // RULE_06
                    next_st.product = '0;
                    // Wide sum shrinks to N bits when top two bits agree (signed) or top bit is zero (unsigned)
                    next_st.narrowable = is_signed ? (ext_sum[W] == ext_sum[W-1])
                        : (ext_sum[W] == 1'b0); // RULE_02
                end
                default:
                begin
                    if (op == fpasm_pkg::OP_MUL_SHIFT)
                    begin
                        // Same loop whatever the binary point; only signed fractions are shifted afterwards
                        for (int i = 0; i < W; i++)
                        begin
                            if (opb[i])
                            begin
                                if (is_signed && i == W - 1)
                                    prod = prod - (mcand_wide << i); // RULE_11
                                else
                                    prod = prod + (mcand_wide << i); // RULE_10 RULE_12
                            end
                        end
                    end
                    else
                    begin
                        // Adjacent-pair scan folded into radix-4 groups
                        for (int k = 0; k < fpasm_pkg::GROUPS; k++)
                            prod = prod + booth_part[k]; // RULE_16
                        // Unsigned multiplier needs a final group above its top bit
                        top_group = (!is_signed && opb[W-1]) ? (mcand_wide << W) : '0;
                        prod = prod + top_group; // RULE_16
                    end
                    mul_ovf = 1'b0;
                    aligned = prod;
                    if (is_frac && is_signed)
                    begin
                        aligned = prod << 1; // RULE_13
                        mul_ovf = (opa == fpasm_pkg::FRAC_MINUS_ONE)
                            && (opb == fpasm_pkg::FRAC_MINUS_ONE); // RULE_15
                    end
                    rounded = aligned;
                    if (round_mode == fpasm_pkg::ROUND_NEAREST)
                        rounded = aligned + fpasm_pkg::ROUND_HALF; // RULE_14
                    tmp = rounded[PW-1:W]; // RULE_14
                    // Rounding a positive maximum can wrap; saturation keeps the sign
                    if (is_signed && !aligned[PW-1] && rounded[PW-1])
                    begin
                        tmp = fpasm_pkg::FRAC_MAX_POS;
                        mul_ovf = 1'b1;
                    end
                    if (mul_ovf && is_frac && is_signed)
                        tmp = fpasm_pkg::FRAC_MAX_POS; // RULE_15
                    next_st.product = aligned;
                    next_st.result = tmp;
                    next_st.sum_wide = '0;
                    next_st.carry_out = 1'b0;
                    next_st.overflow = mul_ovf;
                    next_st.negative = is_signed & tmp[W-1];
                    next_st.narrowable = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            st <= '0;
        else
            st <= next_st; // RULE_18
    end

    assign out_valid = st.out_valid;
    assign sum_wide = st.sum_wide;
    assign result = st.result;
    assign product = st.product;
    assign carry_out = st.carry_out;
    assign overflow = st.overflow;
    assign negative = st.negative;
    assign narrowable = st.narrowable;
endmodule : fpasm_datapath
`default_nettype wire

// File: tb/fpasm_datapath_chk.sv
`timescale 1ns/1ns
`default_nettype none
module fpasm_datapath_chk
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire fpasm_pkg::fpasm_op_t op,
    input wire logic is_signed,
    input wire logic is_frac,
    input wire fpasm_pkg::fpasm_round_t round_mode,
    input wire logic [15:0] opa,
    input wire logic [15:0] opb,
    input wire logic out_valid,
    input wire logic [16:0] sum_wide,
    input wire logic [15:0] result,
    input wire logic [31:0] product,
    input wire logic carry_out,
    input wire logic overflow,
    input wire logic negative,
    input wire logic narrowable
);
    logic addsub;
    logic [16:0] xa;
    logic [16:0] xb;
    assign addsub = op == fpasm_pkg::OP_ADD || op == fpasm_pkg::OP_SUB;
    assign xa = {is_signed & opa[15], opa};
    assign xb = {is_signed & opb[15], opb};
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    chk_take_once: assert property (in_valid |=> out_valid)
        else $error("no answer");
    chk_idle_hold: assert property (!in_valid |=> !out_valid && $stable(result))
        else $error("idle output moved");
    chk_sum_ext: assert property (in_valid && op == fpasm_pkg::OP_ADD |=> sum_wide == $past(xa + xb))
        else $error("wide sum wrong");
    chk_diff_ext: assert property (in_valid && op == fpasm_pkg::OP_SUB |=> sum_wide == $past(xa - xb))
        else $error("wide difference wrong");
    chk_low_half: assert property (in_valid && addsub |=> result == sum_wide[15:0])
        else $error("result not low sum");
    chk_uns_flags: assert property (in_valid && addsub && !is_signed
        |=> overflow == (carry_out ^ $past(op == fpasm_pkg::OP_SUB))) else $error("carry flag wrong");
    chk_sgn_ovf: assert property (in_valid && addsub && is_signed
        |=> overflow == (sum_wide[16] ^ sum_wide[15]) && narrowable == !overflow) else $error("ovf");
    chk_uns_prod: assert property (in_valid && !addsub && !is_signed
        |=> product == $past({16'h0000, opa} * {16'h0000, opb})) else $error("product wrong");
    chk_min_one: assert property (in_valid && !addsub && is_signed && is_frac && opa == 16'h8000
        && opb == 16'h8000 |=> overflow && result == 16'h7fff) else $error("minus one missed");
    cover property (in_valid && addsub && is_signed ##1 overflow);
    cover property (in_valid && op == fpasm_pkg::OP_MUL_BOOTH ##1 out_valid);
    cover property (in_valid && round_mode == fpasm_pkg::ROUND_NEAREST ##1 out_valid);
endmodule : fpasm_datapath_chk
bind fpasm_datapath fpasm_datapath_chk u_chk (.core_clk(core_clk), .nrst(nrst), .in_valid(in_valid),
    .op(op), .is_signed(is_signed), .is_frac(is_frac), .round_mode(round_mode), .opa(opa),
    .opb(opb), .out_valid(out_valid), .sum_wide(sum_wide), .result(result), .product(product),
    .carry_out(carry_out), .overflow(overflow), .negative(negative), .narrowable(narrowable));
`default_nettype wire

// File: tb/fpasm_partner.sv
`timescale 1ns/1ns
`default_nettype none
// Upstream sequencer; mode is {signed, frac, round}
module fpasm_partner
(
    input wire logic core_clk,
    output logic in_valid,
    output fpasm_pkg::fpasm_op_t op,
    output logic is_signed,
    output logic is_frac,
    output fpasm_pkg::fpasm_round_t round_mode,
    output logic [15:0] opa,
    output logic [15:0] opb
);
    initial
    begin
        in_valid = 1'b0;
        {is_signed, is_frac, opa, opb} = 34'h0;
        op = fpasm_pkg::OP_ADD;
        round_mode = fpasm_pkg::ROUND_TRUNC;
    end
    task automatic issue(input logic [2:0] o, input logic [3:0] m, input logic [15:0] a,
        input logic [15:0] b);
        in_valid = 1'b1;
        op = fpasm_pkg::fpasm_op_t'(o);
        {is_signed, is_frac} = m[3:2];
        round_mode = fpasm_pkg::fpasm_round_t'(m[1:0]);
        opa = a;
        opb = b;
        @(posedge core_clk);
        #1;
    endtask : issue
    // Released operands must not look like the last request
    task automatic idle();
        in_valid = 1'b0;
        opa = ~opa;
        opb = ~opb;
    endtask : idle
endmodule : fpasm_partner
`default_nettype wire

// File: tb/tb_fpasm_datapath.sv
`timescale 1ns/1ns
`default_nettype none
module tb_fpasm_datapath;
    logic core_clk;
    logic nrst;
    logic in_valid;
    fpasm_pkg::fpasm_op_t op;
    logic is_signed;
    logic is_frac;
    fpasm_pkg::fpasm_round_t round_mode;
    logic [15:0] opa;
    logic [15:0] opb;
    logic out_valid;
    logic [16:0] sum_wide;
    logic [15:0] result;
    logic [31:0] product;
    logic carry_out;
    logic overflow;
    logic negative;
    logic narrowable;
    int n_mismatch = 0;
    int samples_checked = 0;
    fpasm_partner u_up (.core_clk(core_clk), .in_valid(in_valid), .op(op), .is_signed(is_signed),
        .is_frac(is_frac), .round_mode(round_mode), .opa(opa), .opb(opb));
    fpasm_datapath DUT (.core_clk(core_clk), .nrst(nrst), .in_valid(in_valid), .op(op),
        .is_signed(is_signed), .is_frac(is_frac), .round_mode(round_mode), .opa(opa), .opb(opb),
        .out_valid(out_valid), .sum_wide(sum_wide), .result(result), .product(product),
        .carry_out(carry_out), .overflow(overflow), .negative(negative), .narrowable(narrowable));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Wide enough for the reset snapshot of valid, result and product
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error t=%0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic run(input logic [2:0] o, input logic [3:0] m, input logic [15:0] a,
        input logic [15:0] b);
        u_up.issue(o, m, a, b);
        check(out_valid, 1'b1);
    endtask : run
    task automatic t_addsub();
        run(3'h0, 4'h0, 16'hffff, 16'h0001);
        check({sum_wide, carry_out, overflow}, {17'h10000, 2'b11});
        run(3'h0, 4'h8, 16'hffff, 16'hffff);
        check({sum_wide, overflow, negative, narrowable}, {17'h1fffe, 3'b011});
        run(3'h0, 4'h8, 16'h7fff, 16'h0001);
        check({sum_wide, overflow, narrowable}, {17'h08000, 2'b10});
        run(3'h1, 4'h0, 16'h0005, 16'h0007);
        check({sum_wide, result, overflow, negative}, {17'h1fffe, 16'hfffe, 2'b11});
        run(3'h1, 4'h0, 16'h0007, 16'h0005);
        check({sum_wide, carry_out, negative, narrowable}, {17'h00002, 3'b101});
        run(3'h1, 4'h8, 16'h8000, 16'h0001);
        check({sum_wide, overflow, negative}, {17'h17fff, 2'b11});
        $display("addsub done");
    endtask : t_addsub
    task automatic t_mul();
        for (int k = 2; k < 4; k++)
        begin
            run(k[2:0], 4'h8, 16'hfffd, 16'h0003);
            check(product, 32'hfffffff7);
            run(k[2:0], 4'h0, 16'hffff, 16'hffff);
            check(product, 32'hfffe0001);
            run(k[2:0], 4'h4, 16'hffff, 16'hffff);
            check(product, 32'hfffe0001);
            run(k[2:0], 4'hc, 16'h4000, 16'h4000);
            check({product, result}, {32'h20000000, 16'h2000});
            run(k[2:0], 4'hc, 16'h0001, 16'h4000);
            check(result, 16'h0000);
            run(k[2:0], 4'hd, 16'h0001, 16'h4000);
            check(result, 16'h0001);
            run(k[2:0], 4'hc, 16'h8000, 16'h8000);
            check({result, overflow, negative}, {16'h7fff, 2'b10});
        end
        $display("mul done");
    endtask : t_mul
    task automatic t_idle();
        u_up.idle();
        @(posedge core_clk);
        #1;
        check({out_valid, result}, {1'b0, 16'h7fff});
        $display("idle done");
    endtask : t_idle
    // Low window bits walk every group code, top bits add the sign group
    task automatic t_booth();
        logic [15:0] b;
        // Unsigned holder so the compare does not sign-extend it
        logic [31:0] e;
        for (int i = 0; i < 8; i++)
        begin
            b = {i[1:0], 10'h000, i[2:0], 1'b0};
            e = $signed(16'hfff3) * $signed(b);
            run(3'h3, 4'h8, 16'hfff3, b);
            check(product, e);
        end
        $display("booth done");
    endtask : t_booth
    task automatic stop_test();
        $display("Counts: %0d compared, %0d mismatched", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial
    begin
        nrst = 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        check({out_valid, result, product}, 49'h0);
        t_addsub();
        t_mul();
        t_idle();
        t_booth();
        stop_test();
    end
    initial
    begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule : tb_fpasm_datapath
`default_nettype wire
